// File: rtl/timer_master_trigger_pkg.sv
package timer_master_trigger_pkg;

    // Register byte addresses on the Wishbone slave
    localparam logic [3:0] addr_control_two   = 4'h0;
    localparam logic [3:0] addr_channel_write = 4'h4;
    localparam logic [3:0] addr_channel_live  = 4'h8;
    localparam logic [3:0] addr_status        = 4'hc;

    // Field positions of timer_control_two
    localparam int pos_preload     = 0;
    localparam int pos_reserved    = 1;
    localparam int pos_update_sel  = 2;
    localparam int pos_dma_select  = 3;
    localparam int pos_mode_lsb    = 4;
    localparam int pos_xor_select  = 7;

    localparam logic [15:0] control_two_reset   = 16'h0000;
    localparam logic [15:0] control_two_wmask   = 16'h00fd;

    // Master mode encodings
    localparam logic [2:0] mode_reset     = 3'h0;
    localparam logic [2:0] mode_enable    = 3'h1;
    localparam logic [2:0] mode_update    = 3'h2;
    localparam logic [2:0] mode_cmp_pulse = 3'h3;
    localparam logic [2:0] mode_ref_one   = 3'h4;
    localparam logic [2:0] mode_ref_two   = 3'h5;
    localparam logic [2:0] mode_ref_three = 3'h6;
    localparam logic [2:0] mode_ref_four  = 3'h7;

    // Per channel: output enable, complement enable, 3-bit output mode
    localparam int channel_bits = 5;
    localparam int channel_count = 4;
    localparam logic [19:0] channel_reset = 20'h00000;

    // Trigger output lag behind a trigger-input driven enable
    localparam int sync_delay_cycles = 1;

    typedef struct packed {
        logic       xor_select;
        logic [2:0] mode;
        logic       dma_select;
        logic       update_select;
        logic       preload;
    } control_two_t;

    typedef struct packed {
        logic [3:0] compare_reference;
        logic [3:0] channel_event;
        logic       channel_one_event;
        logic       update_event;
        logic       counter_run_bit;
        logic       gated_trigger;
        logic       trigger_reset;
        logic       master_slave_sync;
        logic       trigger_input;
    } timer_events_t;

    typedef struct packed {
        logic       timer_input_one;
        logic       trigger_output;
        logic       dma_request;
        logic       counter_run_signal;
    } timer_outputs_t;

endpackage

// File: rtl/timer_master_trigger_control.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
// How it works
// - XOR select high feeds input one with pins 1^2^3, else pin 1.
// - Mode 001 puts counter run signal on trigger output.
// - Counter run signal is run bit OR gated trigger input.
// - Trigger-driven enable lags on trigger out unless sync mode set.
// - Mode 010 pulses trigger out on each update event.
// - Mode 011 pulses trigger out on every channel-one flag set.
// - Modes 100..111 drive trigger out from compare reference 1..4.
// - DMA select high requests compare value transfer on update.
// - DMA select low requests transfer on each channel event.
// - Preload with update select high loads on commutation or trigger rise.
// - Preload with update select low loads only on commutation bit.
// - Preload high keeps channel bits in shadow until commutation.
// - Preload low applies channel bit writes at once.
module timer_master_trigger_control #(
    parameter int channels = 4
) (
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    input  wire logic                                  wb_cyc_i,
    input  wire logic                                  wb_stb_i,
    input  wire logic                                  wb_we_i,
    input  wire logic [3:0]                            wb_adr_i,
    input  wire logic [3:0]                            wb_sel_i,
    input  wire logic [31:0]                           wb_dat_i,
    output logic [31:0]                                wb_dat_o,
    output logic                                       wb_ack_o,
    output logic                                       wb_err_o,
    input  wire logic [2:0]                            channel_pins,
    input  wire logic                                  software_update_generate,
    input  wire logic                                  commutation_bit,
    input  wire timer_master_trigger_pkg::timer_events_t events,
    output timer_master_trigger_pkg::timer_outputs_t   outputs,
    output logic [channels*5-1:0]                      channel_active
);

    localparam int cw = channels * timer_master_trigger_pkg::channel_bits;

    timer_master_trigger_pkg::control_two_t control;
    logic [cw-1:0] channel_write;
    logic          trigger_input_last;
    logic [15:0]   next_control;
    logic [31:0]   next_channel;
    logic          commutation;
    logic          run_now;
    logic          next_trigger;
    logic          lagged_run;
    logic          bus_request;

    function automatic logic [15:0] pack_control(
        input timer_master_trigger_pkg::control_two_t c
    );
        logic [15:0] v;
        v = 16'h0000;
        v[timer_master_trigger_pkg::pos_preload] = c.preload;
        v[timer_master_trigger_pkg::pos_update_sel] = c.update_select;
        v[timer_master_trigger_pkg::pos_dma_select] = c.dma_select;
        v[timer_master_trigger_pkg::pos_mode_lsb +: 3] = c.mode;
        v[timer_master_trigger_pkg::pos_xor_select] = c.xor_select;
        return v;
    endfunction

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0]  sel
    );
        logic [31:0] v;
        v = old_value;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                v[b*8 +: 8] = new_value[b*8 +: 8];
            end
        end
        return v;
    endfunction

    assign bus_request = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // Register contents with the enabled byte lanes of the bus data merged in
    always_comb begin
        next_control = 16'(merge_bytes({16'h0000, pack_control(control)},
                                       wb_dat_i, wb_sel_i)) &
                       timer_master_trigger_pkg::control_two_wmask;
        next_channel = merge_bytes(32'(channel_write), wb_dat_i, wb_sel_i);
    end

    // Bus answers one cycle after the request; ack drops the next cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else if (bus_request) begin
            if (wb_adr_i == timer_master_trigger_pkg::addr_control_two ||
                wb_adr_i == timer_master_trigger_pkg::addr_channel_write ||
                wb_adr_i == timer_master_trigger_pkg::addr_channel_live ||
                wb_adr_i == timer_master_trigger_pkg::addr_status) begin
                wb_ack_o <= 1'b1;
                wb_err_o <= 1'b0;
            end else begin
                wb_ack_o <= 1'b0;
                wb_err_o <= 1'b1;
            end
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            control <= '0;
        end else if (bus_request && wb_we_i &&
                     wb_adr_i == timer_master_trigger_pkg::addr_control_two)
        begin
            control.preload <=
                next_control[timer_master_trigger_pkg::pos_preload];
            control.update_select <=
                next_control[timer_master_trigger_pkg::pos_update_sel];
            control.dma_select <=
                next_control[timer_master_trigger_pkg::pos_dma_select];
            control.mode <=
                next_control[timer_master_trigger_pkg::pos_mode_lsb +: 3];
            control.xor_select <=
                next_control[timer_master_trigger_pkg::pos_xor_select];
        end
    end

    // Written channel bits: staging copy when preloaded, live otherwise
    always_ff @(posedge clock) begin
        if (!resetn) begin
            channel_write <= '0;
        end else if (bus_request && wb_we_i &&
                     wb_adr_i == timer_master_trigger_pkg::addr_channel_write)
        begin
            channel_write <= next_channel[cw-1:0];
        end
    end

    always_comb begin
        commutation = commutation_bit;
        if (control.update_select && events.trigger_input &&
            !trigger_input_last) begin
            commutation = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            trigger_input_last <= 1'b0;
        end else begin
            trigger_input_last <= events.trigger_input;
        end
    end

    // Live channel bits
    always_ff @(posedge clock) begin
        if (!resetn) begin
            channel_active <= '0;
        end else if (!control.preload) begin
            channel_active <= channel_write;
        end else if (commutation) begin
            channel_active <= channel_write;
        end
    end

    // Counter run signal
    assign run_now = events.counter_run_bit || events.gated_trigger;

    // Trigger-derived enable is seen one cycle late unless sync mode is on,
    // which lets the master hold off slaves so both start on one edge.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lagged_run <= 1'b0;
        end else begin
            lagged_run <= run_now;
        end
    end

    always_comb begin
        case (control.mode)
            timer_master_trigger_pkg::mode_reset:
                next_trigger = software_update_generate ||
                               events.trigger_reset;
            timer_master_trigger_pkg::mode_enable: begin
                if (events.master_slave_sync) begin
                    next_trigger = run_now;
                end else begin
                    next_trigger = events.counter_run_bit || lagged_run;
                end
            end
            timer_master_trigger_pkg::mode_update:
                next_trigger = events.update_event;
            timer_master_trigger_pkg::mode_cmp_pulse:
                next_trigger = events.channel_one_event;
            timer_master_trigger_pkg::mode_ref_one:
                next_trigger = events.compare_reference[0];
            timer_master_trigger_pkg::mode_ref_two:
                next_trigger = events.compare_reference[1];
            timer_master_trigger_pkg::mode_ref_three:
                next_trigger = events.compare_reference[2];
            default:
                next_trigger = events.compare_reference[3];
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            outputs.trigger_output <= 1'b0;
            outputs.counter_run_signal <= 1'b0;
        end else begin
            outputs.trigger_output <= next_trigger;
            outputs.counter_run_signal <= run_now;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            outputs.timer_input_one <= 1'b0;
        end else if (control.xor_select) begin
            outputs.timer_input_one <= ^channel_pins;
        end else begin
            outputs.timer_input_one <= channel_pins[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            outputs.dma_request <= 1'b0;
        end else if (control.dma_select) begin
            outputs.dma_request <= events.update_event;
        end else begin
            outputs.dma_request <= |events.channel_event;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_request && !wb_we_i) begin
            if (wb_adr_i == timer_master_trigger_pkg::addr_control_two) begin
                wb_dat_o <= {16'h0000, pack_control(control)};
            end else if (wb_adr_i ==
                         timer_master_trigger_pkg::addr_channel_write) begin
                wb_dat_o <= 32'(channel_write);
            end else if (wb_adr_i ==
                         timer_master_trigger_pkg::addr_channel_live) begin
                wb_dat_o <= 32'(channel_active);
            end else if (wb_adr_i == timer_master_trigger_pkg::addr_status) begin
                wb_dat_o <= {28'h0000000, outputs.timer_input_one,
                             outputs.trigger_output, outputs.dma_request,
                             outputs.counter_run_signal};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule

// File: dv/timer_master_trigger_control_chk.sv
`timescale 1ns/1ns
module timer_master_trigger_control_chk #(
    parameter int channels = 4
) (
    input wire logic                                  clock,
    input wire logic                                  resetn,
    input wire logic                                  wb_cyc_i,
    input wire logic                                  wb_stb_i,
    input wire logic                                  wb_we_i,
    input wire logic [3:0]                            wb_adr_i,
    input wire logic [31:0]                           wb_dat_i,
    input wire logic                                  wb_ack_o,
    input wire logic [2:0]                            channel_pins,
    input wire logic                                  software_update_generate,
    input wire logic                                  commutation_bit,
    input wire timer_master_trigger_pkg::timer_events_t  events,
    input wire timer_master_trigger_pkg::timer_outputs_t outputs,
    input wire logic [channels*5-1:0]                 channel_active
);
    logic                  up;
    logic [7:0]            c;
    logic [channels*5-1:0] w;
    wire logic [2:0]       m = c[6:4];
    // Mirror of register writes, taken at the request edge as the design does
    always_ff @(posedge clock) begin
        up <= resetn;
        if (!resetn) begin
            c <= 8'h00;
            w <= '0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
            if (wb_adr_i == timer_master_trigger_pkg::addr_control_two)
                c <= wb_dat_i[7:0] & 8'hfd;
            if (wb_adr_i == timer_master_trigger_pkg::addr_channel_write)
                w <= wb_dat_i[channels*5-1:0];
        end
    end
    default clocking @(posedge clock); endclocking
    // Outputs still hold reset values on the first edge after release
    default disable iff (!resetn || !up);
    AST_XOR_SELECT: assert property (outputs.timer_input_one ==
        ($past(c[7]) ? ^$past(channel_pins) : $past(channel_pins[0])))
        else $error("input one source wrong");
    AST_RUN_OR: assert property (outputs.counter_run_signal ==
        $past(events.counter_run_bit | events.gated_trigger))
        else $error("counter run signal wrong");
    AST_MODE_SW: assert property ($past(m) == 3'h0 |->
        outputs.trigger_output ==
        $past(software_update_generate | events.trigger_reset))
        else $error("mode 0 trigger wrong");
    AST_MODE_SYNC: assert property ($past(m) == 3'h1 &&
        $past(events.master_slave_sync) |-> outputs.trigger_output ==
        $past(events.counter_run_bit | events.gated_trigger))
        else $error("synced enable trigger wrong");
    AST_MODE_UPDATE: assert property ($past(m) == 3'h2 |->
        outputs.trigger_output == $past(events.update_event))
        else $error("update trigger wrong");
    AST_MODE_PULSE: assert property ($past(m) == 3'h3 |->
        outputs.trigger_output == $past(events.channel_one_event))
        else $error("compare pulse trigger wrong");
    AST_MODE_REF: assert property ($past(m[2]) |->
        outputs.trigger_output == $past(events.compare_reference[m[1:0]]))
        else $error("reference trigger wrong");
    AST_DMA: assert property (outputs.dma_request ==
        $past(c[3] ? events.update_event : |events.channel_event))
        else $error("dma request wrong");
    AST_DIRECT: assert property (!$past(c[0]) |->
        channel_active == $past(w)) else $error("channel bits not direct");
    AST_HOLD: assert property ($past(c[0]) && !$past(c[2]) &&
        !$past(commutation_bit) |-> $stable(channel_active))
        else $error("shadow bits leaked");
    AST_COMMUTE: assert property ($past(c[0] && commutation_bit) |->
        channel_active == $past(w)) else $error("commutation load wrong");
    AST_MODE_LAG: assert property ($past(m) == 3'h1 &&
        !$past(events.master_slave_sync) |-> outputs.trigger_output ==
        ($past(events.counter_run_bit) | $past(events.counter_run_bit, 2) |
        $past(events.gated_trigger, 2)))
        else $error("lagged enable trigger wrong");
    AST_TRIG_LOAD: assert property ($past(c[0] && c[2] &&
        events.trigger_input) && !$past(events.trigger_input, 2) |->
        channel_active == $past(w)) else $error("trigger load wrong");
    cover property ($past(m) == 3'h3 && outputs.trigger_output);
    cover property ($past(c[3]) && outputs.dma_request);
    cover property ($past(c[0] && commutation_bit));
endmodule

bind timer_master_trigger_control timer_master_trigger_control_chk #(
    .channels(channels)
) chk (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .channel_pins(channel_pins),
    .software_update_generate(software_update_generate),
    .commutation_bit(commutation_bit), .events(events), .outputs(outputs),
    .channel_active(channel_active));

// File: dv/trigger_slave_model.sv
`timescale 1ns/1ns
// Listening DMA controller that counts transfers; it does not drive the block back
module trigger_slave_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic dma_request,
    output int       transfers
);
    logic dma_q;
    // One transfer per rising request, as a DMA channel would start it
    always_ff @(posedge clock) begin
        dma_q <= dma_request;
        if (!resetn)
            transfers <= 0;
        else if (dma_request && !dma_q)
            transfers <= transfers + 1;
    end
endmodule

// File: dv/tb_timer_master_trigger_control.sv
`timescale 1ns/1ns
module tb_timer_master_trigger_control;
    logic                                     clock, resetn, cyc, stb, we;
    logic                                     sug, com, ack, err, ge;
    logic [3:0]                               adr;
    logic [2:0]                               pins;
    logic [31:0]                              wdat, rdat, rd;
    logic [19:0]                              live;
    timer_master_trigger_pkg::timer_events_t  ev, evn;
    timer_master_trigger_pkg::timer_outputs_t out;
    int                                       bad_count, tests_run, dmas;
    timer_master_trigger_control dut (.clock(clock), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .channel_pins(pins), .software_update_generate(sug),
        .commutation_bit(com), .events(ev), .outputs(out),
        .channel_active(live));
    trigger_slave_model far (.clock(clock), .resetn(resetn),
        .dma_request(out.dma_request), .transfers(dmas));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (ack !== 1'b1 && err !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        rd = rdat;
        ge = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    // Sources are ordered as the master modes: own source only, or all others
    task drive(input int m, input logic own);
        logic [7:0] s;
        s = own ? 8'h01 << m : ~(8'h01 << m);
        evn = '0;
        evn.counter_run_bit = s[1];
        evn.update_event = s[2];
        evn.channel_one_event = s[3];
        evn.compare_reference = s[7:4];
        ev <= evn;
        sug <= s[0];
    endtask
    initial begin
        {resetn, cyc, stb, we, sug, com, adr, pins, wdat} <= '0;
        ev <= '0;
        bad_count = 0;
        tests_run = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(0, 4'h0, 0);
        chk(rd, 0);
        bus(1, 4'h0, 32'h000000ff);
        bus(0, 4'h0, 0);
        chk(rd, 32'h000000fd);
        bus(1, 4'h2, 32'h00000001);
        chk(ge, 1);
        $display("register test done");
        for (int m = 0; m < 8; m++) begin
            bus(1, 4'h0, {25'h0, m[2:0], 4'h0});
            drive(m, 1'b0);
            repeat (3) @(posedge clock);
            chk(out.trigger_output, 0);
            drive(m, 1'b1);
            repeat (3) @(posedge clock);
            chk(out.trigger_output, 1);
        end
        bus(1, 4'h0, 32'h00000010);
        evn = '0;
        evn.gated_trigger = 1'b1;
        evn.master_slave_sync = 1'b1;
        ev <= evn;
        sug <= 1'b0;
        repeat (2) @(posedge clock);
        chk(out.counter_run_signal, 1);
        chk(out.trigger_output, 1);
        bus(0, 4'hc, 0);
        chk(rd, 32'h00000005);
        ev <= '0;
        repeat (2) @(posedge clock);
        evn = '0;
        evn.gated_trigger = 1'b1;
        ev <= evn;
        repeat (2) @(posedge clock);
        chk(out.trigger_output, 0);
        @(posedge clock);
        chk(out.trigger_output, 1);
        $display("master mode test done");
        for (int d = 0; d < 2; d++) begin
            bus(1, 4'h0, {28'h0, d[0], 3'h0});
            evn = '0;
            evn.update_event = 1'b1;
            ev <= evn;
            repeat (3) @(posedge clock);
            chk(out.dma_request, d[0]);
            evn = '0;
            evn.channel_event = 4'h8;
            ev <= evn;
            repeat (3) @(posedge clock);
            chk(out.dma_request, !d[0]);
            ev <= '0;
            repeat (2) @(posedge clock);
        end
        chk(dmas, 2);
        $display("dma test done");
        for (int i = 0; i < 16; i++) begin
            bus(1, 4'h0, {24'h0, i[3], 7'h0});
            pins <= i[2:0];
            repeat (2) @(posedge clock);
            chk(out.timer_input_one, i[3] ? ^i[2:0] : i[0]);
        end
        $display("input select test done");
        bus(1, 4'h0, 0);
        bus(1, 4'h4, 32'h00012345);
        repeat (2) @(posedge clock);
        chk(live, 20'h12345);
        bus(1, 4'h0, 32'h00000001);
        bus(1, 4'h4, 32'h000abcde);
        evn = '0;
        evn.trigger_input = 1'b1;
        ev <= evn;
        repeat (2) @(posedge clock);
        chk(live, 20'h12345);
        bus(0, 4'h4, 0);
        chk(rd, 32'h000abcde);
        com <= 1'b1;
        ev <= '0;
        @(posedge clock);
        com <= 1'b0;
        repeat (2) @(posedge clock);
        chk(live, 20'habcde);
        bus(1, 4'h0, 32'h00000005);
        bus(1, 4'h4, 32'h00000fff);
        evn = '0;
        evn.trigger_input = 1'b1;
        ev <= evn;
        repeat (4) @(posedge clock);
        bus(0, 4'h8, 0);
        chk(rd, 32'h00000fff);
        $display("channel preload test done");
        resetn <= 1'b0;
        ev <= '0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(0, 4'h0, 0);
        chk(rd, 0);
        bus(0, 4'h8, 0);
        chk(rd, 0);
        $display("reset test done");
        stop_test();
    end
endmodule
